// ===== rtl/cstec_health.sv
// Repetition count and adaptive proportion tests on raw entropy bits.
// Assumes the sample stream is already synchronised to the block clock.
`timescale 1ns/1ns
module cstec_health #(
  parameter int RCT_MAX = cstec_pkg::RCT_CUTOFF,
  parameter int APT_WIN = cstec_pkg::APT_WINDOW,
  parameter int APT_MAX = cstec_pkg::APT_CUTOFF,
  parameter int START_N = cstec_pkg::STARTUP_SAMPLES
) (
  input wire logic clk, // Block clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic smp_valid, // One raw bit is present.
  input wire logic smp_bit, // Raw entropy bit.
  output logic fail, // Sticky health failure.
  output logic start_done, // Start-up sample count reached.
  output logic good // Pulse: a sample passed both tests.
);
  logic last, next_last, next_fail, next_start_done, next_good;
  logic apt_ref, next_apt_ref;
  logic [15:0] run, next_run, win, next_win, hits, next_hits;
  logic [15:0] seen, next_seen;

  // Runs both tests on each sample; the window restarts after APT_WIN bits.
  always_comb begin
    next_last = last;
    next_run = run;
    next_win = win;
    next_hits = hits;
    next_apt_ref = apt_ref;
    next_seen = seen;
    next_fail = fail;
    next_start_done = start_done;
    next_good = 1'b0;
    if (smp_valid) begin
      next_last = smp_bit;
      next_run = (smp_bit == last) ? run + 16'h0001 : 16'h0001;
      if (win == 16'(APT_WIN) || win == 16'h0000) begin
        next_win = 16'h0001;
        next_apt_ref = smp_bit;
        next_hits = 16'h0001;
      end else begin
        next_win = win + 16'h0001;
        next_hits = hits + {15'h0000, smp_bit == apt_ref};
      end
      if (next_run >= 16'(RCT_MAX) || next_hits >= 16'(APT_MAX)) begin
        next_fail = 1'b1;
      end
      next_good = !next_fail;
      if (seen != 16'(START_N)) begin
        next_seen = seen + 16'h0001;
      end
      next_start_done = (next_seen == 16'(START_N));
    end
  end

  // Registers the test counters.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
      run <= 16'h0000;
      win <= 16'h0000;
      hits <= 16'h0000;
      apt_ref <= 1'b0;
      seen <= 16'h0000;
      fail <= 1'b0;
      start_done <= 1'b0;
      good <= 1'b0;
    end else begin
      last <= next_last;
      run <= next_run;
      win <= next_win;
      hits <= next_hits;
      apt_ref <= next_apt_ref;
      seen <= next_seen;
      fail <= next_fail;
      start_done <= next_start_done;
      good <= next_good;
    end
  end
endmodule

// ===== rtl/cstec_integ.sv
// Firmware image integrity check by interleaved byte parity.
// Assumes bytes arrive on the block clock: image bytes, then parity bytes.
`timescale 1ns/1ns
module cstec_integ #(
  parameter int LANES = cstec_pkg::FW_PARITY_BYTES
) (
  input wire logic clk, // Block clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic byte_valid, // A byte is offered this cycle.
  input wire logic [7:0] byte_in, // Image or reference parity byte.
  input wire logic byte_last, // Marks the last image byte.
  output logic done, // Check has finished.
  output logic pass // All parity lanes matched.
);
  localparam int IW = $clog2(LANES);
  localparam logic [IW-1:0] LAST_IDX = IW'(LANES - 1);
  logic [7:0] par [LANES];
  logic [7:0] next_par [LANES];
  logic [IW-1:0] idx, next_idx;
  logic cmp, next_cmp, bad, next_bad, next_done;

  // Image bytes fold into lanes; then each lane is compared to its byte.
  always_comb begin
    next_par = par;
    next_idx = idx;
    next_cmp = cmp;
    next_bad = bad;
    next_done = done;
    if (byte_valid && !done) begin
      next_idx = (idx == LAST_IDX) ? '0 : idx + 1'b1;
      if (!cmp) begin
        next_par[idx] = par[idx] ^ byte_in;
        if (byte_last) begin
          next_cmp = 1'b1;
          next_idx = '0;
        end
      end else begin
        next_bad = bad | (par[idx] != byte_in);
        next_done = (idx == LAST_IDX);
      end
    end
  end

  // Registers the parity lanes and progress.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LANES; i++) begin
        par[i] <= 8'h00;
      end
      idx <= '0;
      cmp <= 1'b0;
      bad <= 1'b0;
      done <= 1'b0;
    end else begin
      par <= next_par;
      idx <= next_idx;
      cmp <= next_cmp;
      bad <= next_bad;
      done <= next_done;
    end
  end

  assign pass = done && !bad;
endmodule

// ===== rtl/cstec_pkg.sv
// Constants and types shared by the self-test and error control block.
// Assumes a single 20 MHz clock and an active-low asynchronous reset.
package cstec_pkg;
  localparam int FW_PARITY_BYTES = 428;
  localparam int DRBG_ENT_BITS = 512;
  localparam int XTS_KEY_BITS = 512;
  localparam int SHA_MSG_BITS = 256;
  localparam int RSA_MOD_BITS = 3072;
  localparam int KEY_ENT_BITS = 256;
  // Entropy rate is 1/2 bit per raw bit, so a key needs twice its entropy.
  localparam int ENT_RATE_DEN = 2;
  localparam int SEED_BITS = KEY_ENT_BITS * ENT_RATE_DEN;
  localparam int RCT_CUTOFF = 32;
  localparam int APT_WINDOW = 512;
  localparam int APT_CUTOFF = 410;
  localparam int STARTUP_SAMPLES = 1024;
  localparam logic [7:0] SC_NS_NOT_READY = 8'h82;
  localparam logic [7:0] SC_INTERNAL_ERR = 8'h06;
  localparam logic [2:0] SCT_GENERIC = 3'h0;
  // Fixed text shown in the revision field in fail mode: "ERRORMOD".
  localparam logic [63:0] FR_ERROR_MARK = 64'h4552524F524D4F44;
  localparam logic [11:0] LEN_DRBG = 12'(DRBG_ENT_BITS);
  localparam logic [11:0] LEN_XTS = 12'(XTS_KEY_BITS);
  localparam logic [11:0] LEN_SHA = 12'(SHA_MSG_BITS);
  localparam logic [11:0] LEN_RSA = 12'(RSA_MOD_BITS);

  typedef enum logic [2:0] {
    T_DRBG = 3'h0,
    T_XTS_ENC = 3'h1,
    T_XTS_DEC = 3'h2,
    T_SHA = 3'h3,
    T_RSA = 3'h4,
    T_FWLOAD = 3'h5
  } cstec_test_t;

  typedef enum logic [2:0] {
    S_INTEG = 3'h0,
    S_ENT_START = 3'h1,
    S_KAT = 3'h2,
    S_OPER = 3'h3,
    S_FWLOAD = 3'h4,
    S_HANG = 3'h5,
    S_FAIL = 3'h6
  } cstec_state_t;
endpackage

// ===== rtl/cstec_top.sv
// Self-test sequencer and error-state control of a self-encrypting drive.
// Assumes test engines and command decode share CLK; entropy is a pin.
//
// Notes on behaviour
// - Data output held while tests run.
// - Test failure enters error, output blocked.
// - Boot checks firmware with 428-byte parity.
// - Boot check failures hang, silent, no crypto.
// - Only power cycle leaves error state.
// - Unsupported IO: status 0x82, type 0x0.
// - Other unsupported: status 0x6, type 0x0.
// - No crypto service in error state.
// - DRBG known-answer test, 512-bit entropy.
// - Cipher encrypt, decrypt tests, 512-bit key.
// - SHA-256 test over 256-bit message.
// - Signature verify test, 3072-bit modulus.
// - New firmware verified by signature first.
// - Entropy start-up health test after reset.
// - Continuous entropy health tests always run.
// - At least 256 entropy bits per key.
// - Keys are unmodified DRBG output.
// - Cipher key halves never identical.
// - No secret parameters on any output.
// - Half bit entropy per bit, 512-bit seed.
`timescale 1ns/1ns
module cstec_top (
  input wire logic CLK, // 20 MHz clock.
  input wire logic RESETN, // Asynchronous reset, active low.
  input wire logic ENT_VALID, // Entropy source sample strobe (pin).
  input wire logic ENT_BIT, // Entropy source raw bit (pin).
  input wire logic FW_VALID, // Boot image byte strobe.
  input wire logic [7:0] FW_BYTE, // Boot image or parity byte.
  input wire logic FW_LAST, // Last image byte, parity follows.
  output logic TEST_START, // Pulse: start the selected test.
  output logic [2:0] TEST_SEL, // Test being run.
  output logic [11:0] TEST_LEN, // Operand size of that test in bits.
  input wire logic TEST_DONE, // Pulse: engine finished.
  input wire logic TEST_PASS, // Result with TEST_DONE.
  input wire logic FWL_REQ, // Pulse: new firmware downloaded.
  output logic FWL_ACCEPT, // Pulse: new firmware accepted.
  input wire logic KEY_REQ, // Pulse: key generation wanted.
  input wire logic KEY_HALF_EQ, // Candidate key halves are equal.
  output logic KEY_GRANT, // Pulse: load DRBG output as key.
  output logic KEY_RETRY, // Pulse: draw a new candidate.
  output logic SEED_READY, // Enough entropy for one key.
  input wire logic CMD_VALID, // Pulse: host command arrived.
  input wire logic CMD_IS_IO, // Command is an IO command.
  input wire logic CMD_SUPPORTED, // Command is served in fail mode.
  output logic CMD_FWD, // Pulse: pass command to firmware.
  output logic CPL_VALID, // Pulse: rejection completion.
  output logic [7:0] CPL_SC, // Status code.
  output logic [2:0] CPL_SCT, // Status code type.
  input wire logic [63:0] FW_REV, // Normal revision text.
  output logic [63:0] FR_TEXT, // Revision field shown to host.
  output logic DATA_OUT_EN, // Data output allowed.
  output logic CRYPTO_EN, // Crypto services allowed.
  output logic STATUS_EN // Status output allowed.
);
  localparam int CW = $clog2(cstec_pkg::SEED_BITS + 1);
  localparam logic [CW-1:0] SEED_FULL = CW'(cstec_pkg::SEED_BITS);
  cstec_pkg::cstec_state_t state, next_state;
  cstec_pkg::cstec_test_t sel, next_sel;
  logic ent_v1, ent_v2, ent_b1, ent_b2;
  logic busy, next_busy, next_start;
  logic [CW-1:0] ent_cnt, next_ent_cnt;
  logic next_grant, next_retry, next_accept;
  logic next_fwd, next_cpl;
  logic [7:0] next_sc;
  logic integ_done, integ_pass, h_fail, h_start, h_good;

  // Operand size for each test.
  function automatic logic [11:0] test_len(cstec_pkg::cstec_test_t t);
    unique case (t)
      cstec_pkg::T_DRBG: test_len = cstec_pkg::LEN_DRBG;
      cstec_pkg::T_XTS_ENC, cstec_pkg::T_XTS_DEC:
        test_len = cstec_pkg::LEN_XTS;
      cstec_pkg::T_SHA: test_len = cstec_pkg::LEN_SHA;
      cstec_pkg::T_RSA, cstec_pkg::T_FWLOAD: test_len = cstec_pkg::LEN_RSA;
      default: test_len = 12'h000;
    endcase
  endfunction

  // Two-stage synchronisers for the entropy source pins.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ent_v1 <= 1'b0;
      ent_v2 <= 1'b0;
      ent_b1 <= 1'b0;
      ent_b2 <= 1'b0;
    end else begin
      ent_v1 <= ENT_VALID;
      ent_v2 <= ent_v1;
      ent_b1 <= ENT_BIT;
      ent_b2 <= ent_b1;
    end
  end

  cstec_integ u_integ (
    .clk(CLK),
    .rst_n(RESETN),
    .byte_valid(FW_VALID),
    .byte_in(FW_BYTE),
    .byte_last(FW_LAST),
    .done(integ_done),
    .pass(integ_pass)
  );

  cstec_health u_health (
    .clk(CLK),
    .rst_n(RESETN),
    .smp_valid(ent_v2),
    .smp_bit(ent_b2),
    .fail(h_fail),
    .start_done(h_start),
    .good(h_good)
  );

  // Sequencer: boot checks, known-answer tests, operation and errors.
  always_comb begin
    next_state = state;
    next_sel = sel;
    next_busy = busy;
    next_start = 1'b0;
    next_accept = 1'b0;
    unique case (state)
      cstec_pkg::S_INTEG: begin
        if (integ_done) begin
          next_state = integ_pass ? cstec_pkg::S_ENT_START
                                  : cstec_pkg::S_HANG;
        end
      end
      cstec_pkg::S_ENT_START: begin
        if (h_fail) begin
          next_state = cstec_pkg::S_HANG;
        end else if (h_start) begin
          next_state = cstec_pkg::S_KAT;
          next_sel = cstec_pkg::T_DRBG;
        end
      end
      cstec_pkg::S_KAT: begin
        if (h_fail || (busy && TEST_DONE && !TEST_PASS)) begin
          next_state = cstec_pkg::S_FAIL;
          next_busy = 1'b0;
        end else if (!busy) begin
          next_start = 1'b1;
          next_busy = 1'b1;
        end else if (TEST_DONE) begin
          next_busy = 1'b0;
          if (sel == cstec_pkg::T_RSA) begin
            next_state = cstec_pkg::S_OPER;
          end else begin
            next_sel = cstec_pkg::cstec_test_t'(sel + 3'h1);
          end
        end
      end
      cstec_pkg::S_OPER: begin
        if (h_fail) begin
          next_state = cstec_pkg::S_FAIL;
        end else if (FWL_REQ) begin
          next_state = cstec_pkg::S_FWLOAD;
          next_sel = cstec_pkg::T_FWLOAD;
          next_start = 1'b1;
          next_busy = 1'b1;
        end
      end
      cstec_pkg::S_FWLOAD: begin
        if (h_fail || (TEST_DONE && !TEST_PASS)) begin
          next_state = cstec_pkg::S_FAIL;
          next_busy = 1'b0;
        end else if (TEST_DONE) begin
          next_state = cstec_pkg::S_OPER;
          next_busy = 1'b0;
          next_accept = 1'b1;
        end
      end
      cstec_pkg::S_HANG, cstec_pkg::S_FAIL: next_state = state;
      default: next_state = cstec_pkg::S_HANG;
    endcase
  end

  // Entropy accounting and key release; keys come straight from the DRBG.
  always_comb begin
    next_ent_cnt = ent_cnt;
    next_grant = 1'b0;
    next_retry = 1'b0;
    if (h_good && ent_cnt != SEED_FULL) begin
      next_ent_cnt = ent_cnt + 1'b1;
    end
    if (state == cstec_pkg::S_OPER && KEY_REQ && ent_cnt == SEED_FULL &&
        next_state != cstec_pkg::S_FAIL) begin
      if (KEY_HALF_EQ) begin
        next_retry = 1'b1;
      end else begin
        next_grant = 1'b1;
        next_ent_cnt = '0;
      end
    end
  end

  // Host command handling in operation and in fail mode.
  always_comb begin
    next_fwd = 1'b0;
    next_cpl = 1'b0;
    next_sc = CPL_SC;
    if (CMD_VALID) begin
      if (state == cstec_pkg::S_OPER || state == cstec_pkg::S_FWLOAD ||
          (state == cstec_pkg::S_FAIL && CMD_SUPPORTED)) begin
        next_fwd = 1'b1;
      end else if (state == cstec_pkg::S_FAIL) begin
        next_cpl = 1'b1;
        next_sc = CMD_IS_IO ? cstec_pkg::SC_NS_NOT_READY
                            : cstec_pkg::SC_INTERNAL_ERR;
      end
    end
  end

  // Registers state and every output.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= cstec_pkg::S_INTEG;
      sel <= cstec_pkg::T_DRBG;
      busy <= 1'b0;
      ent_cnt <= '0;
      TEST_START <= 1'b0;
      TEST_SEL <= 3'h0;
      TEST_LEN <= 12'h000;
      FWL_ACCEPT <= 1'b0;
      KEY_GRANT <= 1'b0;
      KEY_RETRY <= 1'b0;
      SEED_READY <= 1'b0;
      CMD_FWD <= 1'b0;
      CPL_VALID <= 1'b0;
      CPL_SC <= 8'h00;
      CPL_SCT <= 3'h0;
      FR_TEXT <= 64'h0000000000000000;
      DATA_OUT_EN <= 1'b0;
      CRYPTO_EN <= 1'b0;
      STATUS_EN <= 1'b0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      busy <= next_busy;
      ent_cnt <= next_ent_cnt;
      TEST_START <= next_start;
      TEST_SEL <= next_sel;
      TEST_LEN <= test_len(next_sel);
      FWL_ACCEPT <= next_accept;
      KEY_GRANT <= next_grant;
      KEY_RETRY <= next_retry;
      SEED_READY <= (next_ent_cnt == SEED_FULL);
      CMD_FWD <= next_fwd;
      CPL_VALID <= next_cpl;
      CPL_SC <= next_sc;
      CPL_SCT <= cstec_pkg::SCT_GENERIC;
      FR_TEXT <= (next_state == cstec_pkg::S_FAIL) ?
                 cstec_pkg::FR_ERROR_MARK : FW_REV;
      DATA_OUT_EN <= (next_state == cstec_pkg::S_OPER);
      CRYPTO_EN <= (next_state == cstec_pkg::S_OPER ||
                    next_state == cstec_pkg::S_FWLOAD);
      STATUS_EN <= (next_state == cstec_pkg::S_OPER ||
                    next_state == cstec_pkg::S_FWLOAD ||
                    next_state == cstec_pkg::S_FAIL);
    end
  end

  // Checks on the sequencer and command answers.
  sequence s_unsup(logic io);
    state == cstec_pkg::S_FAIL && CMD_VALID && !CMD_SUPPORTED &&
      CMD_IS_IO == io;
  endsequence
  sequence s_cpl(logic [7:0] sc);
    CPL_VALID && CPL_SC == sc && CPL_SCT == 3'h0 && !CMD_FWD;
  endsequence

  property p_out_oper;
    @(posedge CLK) disable iff (!RESETN)
      DATA_OUT_EN |-> state == cstec_pkg::S_OPER && !busy;
  endproperty
  a_out_oper: assert property (p_out_oper)
    else $error("Data output enabled outside operation.");

  property p_err_block;
    @(posedge CLK) disable iff (!RESETN)
      (state == cstec_pkg::S_FAIL || state == cstec_pkg::S_HANG)
      |-> !DATA_OUT_EN [*3];
  endproperty
  a_err_block: assert property (p_err_block)
    else $error("Data output enabled in error state.");

  property p_hang_quiet;
    @(posedge CLK) disable iff (!RESETN)
      state == cstec_pkg::S_HANG |-> !CPL_VALID && !CMD_FWD &&
      !STATUS_EN && !CRYPTO_EN && !TEST_START;
  endproperty
  a_hang_quiet: assert property (p_hang_quiet)
    else $error("Hung device produced activity.");

  property p_err_stays;
    @(posedge CLK) disable iff (!RESETN)
      state inside {cstec_pkg::S_FAIL, cstec_pkg::S_HANG}
      |=> state == $past(state);
  endproperty
  a_err_stays: assert property (p_err_stays)
    else $error("Error state left without reset.");

  property p_fr_mark;
    @(posedge CLK) disable iff (!RESETN)
      state == cstec_pkg::S_FAIL |-> FR_TEXT == 64'h4552524F524D4F44;
  endproperty
  a_fr_mark: assert property (p_fr_mark)
    else $error("Fail mode without revision marker.");

  property p_io_rej;
    @(posedge CLK) disable iff (!RESETN)
      s_unsup(1'b1) |=> s_cpl(8'h82);
  endproperty
  a_io_rej: assert property (p_io_rej)
    else $error("IO command not rejected as not ready.");

  property p_adm_rej;
    @(posedge CLK) disable iff (!RESETN)
      s_unsup(1'b0) |=> s_cpl(8'h06);
  endproperty
  a_adm_rej: assert property (p_adm_rej)
    else $error("Command not rejected as internal error.");

  property p_crypto_off;
    @(posedge CLK) disable iff (!RESETN)
      (state == cstec_pkg::S_FAIL || state == cstec_pkg::S_HANG)
      |-> !CRYPTO_EN && !KEY_GRANT;
  endproperty
  a_crypto_off: assert property (p_crypto_off)
    else $error("Crypto service offered in error state.");

  property p_kat_order;
    @(posedge CLK) disable iff (!RESETN)
      $rose(state == cstec_pkg::S_KAT) |->
      $past(state) == cstec_pkg::S_ENT_START && integ_pass && h_start;
  endproperty
  a_kat_order: assert property (p_kat_order)
    else $error("Algorithm tests began before boot checks.");

  property p_key_ent;
    @(posedge CLK) disable iff (!RESETN)
      KEY_GRANT |-> $past(ent_cnt) == SEED_FULL && ent_cnt == '0;
  endproperty
  a_key_ent: assert property (p_key_ent)
    else $error("Key granted without a full seed.");

  property p_key_halves;
    @(posedge CLK) disable iff (!RESETN)
      KEY_GRANT |-> !$past(KEY_HALF_EQ) && !KEY_RETRY;
  endproperty
  a_key_halves: assert property (p_key_halves)
    else $error("Key granted with equal halves.");
endmodule

// ===== tb/cstec_host_model.sv
// Host model that issues storage commands to the self-test block.
// Assumes the bench pulses go for one cycle per command.
`timescale 1ns/1ns
module cstec_host_model (
  input wire logic clk, // Block clock.
  input wire logic go, // Send one command.
  input wire logic io, // Kind of the command to send.
  input wire logic supp, // Whether it is served in fail mode.
  output logic cmd_valid, // Command strobe.
  output logic cmd_is_io, // Kind, valid with the strobe.
  output logic cmd_supported // Support flag, valid with the strobe.
);
  // Start from a known idle state.
  initial begin
    cmd_valid = 1'b0;
    cmd_is_io = 1'b0;
    cmd_supported = 1'b0;
  end

  // Qualifiers flip outside a command so stale values never match.
  always @(posedge clk) begin
    cmd_valid <= go;
    cmd_is_io <= go ? io : ~cmd_is_io;
    cmd_supported <= go ? supp : ~cmd_supported;
  end
endmodule

// ===== tb/tb_cstec_top.sv
// Self-checking bench for the self-test and error control block.
// Assumes the host model file is compiled first.
`timescale 1ns/1ns
module tb_cstec_top;
  localparam logic [63:0] REV = 64'h0123456789ABCDEF;
  logic CLK, RESETN, ENT_BIT, FW_VALID, FW_LAST, TEST_DONE, TEST_PASS;
  logic FWL_REQ, KEY_REQ, KEY_HALF_EQ, CMD_VALID, CMD_IS_IO, CMD_SUPPORTED;
  logic TEST_START, FWL_ACCEPT, KEY_GRANT, KEY_RETRY, SEED_READY, CMD_FWD;
  logic CPL_VALID, DATA_OUT_EN, CRYPTO_EN, STATUS_EN;
  logic host_go, host_io, host_supp, ent_stuck;
  logic [7:0] FW_BYTE, CPL_SC;
  logic [2:0] TEST_SEL, CPL_SCT, fail_sel;
  logic [11:0] TEST_LEN;
  logic [63:0] FR_TEXT;
  logic [2:0] sel_log [0:7];
  logic [11:0] len_log [0:7];
  int n_starts, eng_cnt, errors, tests_run;

  cstec_top u_cstec_top (.CLK(CLK), .RESETN(RESETN), .ENT_VALID(1'b1),
    .ENT_BIT(ENT_BIT), .FW_VALID(FW_VALID), .FW_BYTE(FW_BYTE),
    .FW_LAST(FW_LAST), .TEST_START(TEST_START), .TEST_SEL(TEST_SEL),
    .TEST_LEN(TEST_LEN), .TEST_DONE(TEST_DONE), .TEST_PASS(TEST_PASS),
    .FWL_REQ(FWL_REQ), .FWL_ACCEPT(FWL_ACCEPT), .KEY_REQ(KEY_REQ),
    .KEY_HALF_EQ(KEY_HALF_EQ), .KEY_GRANT(KEY_GRANT),
    .KEY_RETRY(KEY_RETRY), .SEED_READY(SEED_READY),
    .CMD_VALID(CMD_VALID), .CMD_IS_IO(CMD_IS_IO),
    .CMD_SUPPORTED(CMD_SUPPORTED), .CMD_FWD(CMD_FWD),
    .CPL_VALID(CPL_VALID), .CPL_SC(CPL_SC), .CPL_SCT(CPL_SCT),
    .FW_REV(REV), .FR_TEXT(FR_TEXT), .DATA_OUT_EN(DATA_OUT_EN),
    .CRYPTO_EN(CRYPTO_EN), .STATUS_EN(STATUS_EN));

  cstec_host_model u_cstec_host_model (.clk(CLK), .go(host_go),
    .io(host_io), .supp(host_supp), .cmd_valid(CMD_VALID),
    .cmd_is_io(CMD_IS_IO), .cmd_supported(CMD_SUPPORTED));

  // Free-running 50 ns clock.
  always #25 CLK = ~CLK;

  // Entropy bit toggles, or sticks at one to trip the health tests.
  always @(posedge CLK) ENT_BIT <= ent_stuck | ~ENT_BIT;

  // Test engine stand-in: logs each start and answers three cycles later.
  always @(posedge CLK) begin
    TEST_DONE <= (eng_cnt == 1);
    TEST_PASS <= (eng_cnt == 1) ? (TEST_SEL !== fail_sel) : ~TEST_PASS;
    if (TEST_START === 1'b1) begin
      check(DATA_OUT_EN, 64'h0);
      if (n_starts < 8) begin
        sel_log[n_starts] = TEST_SEL;
        len_log[n_starts] = TEST_LEN;
      end
      n_starts++;
      eng_cnt <= 3;
    end else if (eng_cnt > 0) begin
      eng_cnt <= eng_cnt - 1;
    end
  end

  // Compares one value and counts the result.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h want %0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Selects the condition that a bounded wait looks for.
  function automatic logic probe(input int k);
    case (k)
      0: probe = DATA_OUT_EN;
      1: probe = SEED_READY;
      2: probe = FWL_ACCEPT;
      default: probe = (FR_TEXT === cstec_pkg::FR_ERROR_MARK);
    endcase
  endfunction

  // Waits at most n cycles for a condition; a timeout ends the run.
  task automatic wait_on(input int k, input int n);
    for (int i = 0; i < n && probe(k) !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    if (probe(k) !== 1'b1) begin
      errors++;
      $display("[ERR] %0t wait timed out on %0d", $time, k);
      complete_run;
    end
  endtask

  task automatic do_reset;
    @(posedge CLK);
    RESETN <= 1'b0;
    n_starts = 0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
  endtask

  // one image byte then 428 parity bytes
  task automatic boot_stream(input logic [7:0] p0);
    @(posedge CLK);
    FW_VALID <= 1'b1;
    FW_BYTE <= 8'hA5;
    FW_LAST <= 1'b1;
    for (int j = 0; j < cstec_pkg::FW_PARITY_BYTES; j++) begin
      @(posedge CLK);
      FW_LAST <= 1'b0;
      FW_BYTE <= (j == 0) ? p0 : 8'h00;
    end
    @(posedge CLK);
    FW_VALID <= 1'b0;
  endtask

  // Sends one host command and judges the answer one cycle later.
  task automatic send_cmd(input logic io, supp, fwd, cpl,
                          input logic [7:0] sc);
    @(posedge CLK);
    host_go <= 1'b1;
    host_io <= io;
    host_supp <= supp;
    @(posedge CLK);
    host_go <= 1'b0;
    @(posedge CLK);
    #1;
    check(CMD_FWD, fwd);
    check(CPL_VALID, cpl);
    if (cpl) begin
      check(CPL_SC, sc);
      check(CPL_SCT, cstec_pkg::SCT_GENERIC);
    end
  endtask

  // Requests a key and judges grant and retry.
  task automatic key_req(input logic h, grant, retry);
    @(posedge CLK);
    KEY_REQ <= 1'b1;
    KEY_HALF_EQ <= h;
    @(posedge CLK);
    KEY_REQ <= 1'b0;
    KEY_HALF_EQ <= ~h;
    #1;
    check(KEY_GRANT, grant);
    check(KEY_RETRY, retry);
  endtask

  // Clean boot: integrity, start-up health, then the five tests in order.
  task automatic t_boot_ok;
    logic [11:0] lens [0:4];
    lens = '{12'h200, 12'h200, 12'h200, 12'h100, 12'hC00};
    do_reset;
    boot_stream(8'hA5);
    wait_on(0, 4000);
    check(n_starts, 5);
    for (int i = 0; i < 5; i++) begin
      check(sel_log[i], i);
      check(len_log[i], lens[i]);
    end
    check(CRYPTO_EN, 1);
    check(STATUS_EN, 1);
    check(FR_TEXT, REV);
  endtask

  // Keys in operation, then a forwarded command.
  task automatic t_keys;
    wait_on(1, 2000);
    key_req(1'b1, 1'b0, 1'b1);
    key_req(1'b0, 1'b1, 1'b0);
    check(SEED_READY, 0);
    send_cmd(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
  endtask

  // New firmware is checked before it is accepted.
  task automatic t_fwload;
    @(posedge CLK);
    FWL_REQ <= 1'b1;
    @(posedge CLK);
    FWL_REQ <= 1'b0;
    #1;
    check(TEST_START, 1);
    check(TEST_SEL, cstec_pkg::T_FWLOAD);
    check(TEST_LEN, 12'hC00);
    check(DATA_OUT_EN, 0);
    wait_on(2, 100);
    check(DATA_OUT_EN, 1);
  endtask

  // Continuous health failure in operation enters fail mode.
  task automatic t_cont;
    ent_stuck = 1'b1;
    wait_on(3, 300);
    check(DATA_OUT_EN, 0);
    ent_stuck = 1'b0;
  endtask

  // Hash test fails: fail mode with fixed rejection codes.
  task automatic t_fail_mode;
    fail_sel = cstec_pkg::T_SHA;
    do_reset;
    boot_stream(8'hA5);
    wait_on(3, 4000);
    check(n_starts, 4);
    check(DATA_OUT_EN, 0);
    check(CRYPTO_EN, 0);
    check(STATUS_EN, 1);
    check(FR_TEXT, cstec_pkg::FR_ERROR_MARK);
    send_cmd(1'b1, 1'b0, 1'b0, 1'b1, 8'h82);
    send_cmd(1'b0, 1'b0, 1'b0, 1'b1, 8'h06);
    send_cmd(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
    key_req(1'b0, 1'b0, 1'b0);
    fail_sel = 3'h7;
  endtask

  // Boot failure hangs silently; negative check over a fixed span.
  task automatic t_hang(input logic [7:0] p0, input logic stuck);
    ent_stuck = stuck;
    do_reset;
    boot_stream(p0);
    repeat (2000) @(posedge CLK);
    #1;
    check(n_starts, 0);
    check(DATA_OUT_EN, 0);
    check(CRYPTO_EN, 0);
    check(STATUS_EN, 0);
    send_cmd(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    ent_stuck = 1'b0;
  endtask

  // Main sequence, ending with recovery through a fresh power cycle.
  initial begin
    CLK = 1'b0;
    RESETN = 1'b0;
    {ENT_BIT, FW_VALID, FW_LAST, TEST_DONE, TEST_PASS} = '0;
    {FWL_REQ, KEY_REQ, KEY_HALF_EQ, host_go, host_io, host_supp} = '0;
    FW_BYTE = 8'h00;
    ent_stuck = 1'b0;
    fail_sel = 3'h7;
    {n_starts, eng_cnt, errors, tests_run} = '0;
    t_boot_ok;
    t_keys;
    t_fwload;
    t_cont;
    t_fail_mode;
    t_hang(8'h5A, 1'b0);
    t_hang(8'hA5, 1'b1);
    t_boot_ok;
    complete_run;
  end
endmodule
